/* File: testbench/avm_base_model.sv */
// Base unit model: gathers the display stream and keeps the last value shown for each data identifier.
`timescale 1ns/1ps
`default_nettype none
module avm_base_model import avm_pkg::*; (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic rst,
	// Display stream from the monitoring core.
	input wire logic [2:0] disp_id,
	input wire logic [15:0] disp_value,
	input wire logic disp_valid,
	// Gathered values, identifier k at bits [(k-1)*16 +: 16].
	output logic [N_DIAG*16-1:0] shown_q
);
	always_ff @(posedge core_clk) begin
		if (rst) begin
			shown_q <= '0;
		end else if (disp_valid && disp_id < 3'(N_DIAG)) begin
			shown_q[disp_id*16 +: 16] <= disp_value;
		end
	end
endmodule
`default_nettype wire

/* File: testbench/tb.sv */
// Self-checking testbench for the analogue value monitoring core.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin num_errors++; \
	$display("Error at %0t: got %h expected %h", $time, (got), (exp)); end end
module tb import avm_pkg::*; ;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic signed [15:0] ch0 = '0, ch1 = '0, ch2 = '0, ch3 = '0;
	logic [7:0] reg_addr = '0;
	logic [31:0] reg_wdata = '0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata, rdv, rdv2;
	logic [1:0] thr_out;
	logic range_out, ramp_enable, disp_valid, irq;
	logic signed [31:0] diff_value;
	logic [95:0] fb_data, shown;
	logic [2:0] disp_id;
	logic [15:0] disp_value;
	int num_errors = 0;
	int checks_done = 0;
	int cycles = 0;

	// A short millisecond keeps ramp and differential runs brief.
	avm_core #(.TICKS_MS(10)) u_avm_core (.core_clk(core_clk), .rst(rst), .analog_channel_zero(ch0),
		.analog_channel_one(ch1), .analog_channel_two(ch2), .analog_channel_three(ch3), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .thr_out(thr_out),
		.range_out(range_out), .ramp_enable(ramp_enable), .diff_value(diff_value), .fb_data(fb_data),
		.disp_id(disp_id), .disp_value(disp_value), .disp_valid(disp_valid), .irq(irq));
	avm_base_model u_avm_base_model (.core_clk(core_clk), .rst(rst), .disp_id(disp_id),
		.disp_value(disp_value), .disp_valid(disp_valid), .shown_q(shown));

	initial begin
		forever #2.5 core_clk = ~core_clk;
	end

	task automatic wrap_up();
		$display("Checks %0d, errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// The run needs some ten and a half thousand cycles, mostly the per-second ramp; a hang is cut off well beyond that.
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 40000) begin
			num_errors++;
			wrap_up();
		end
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	// Other results may stand between interval ends, so wait a bounded time for the expected one.
	task automatic wait_diff(input logic signed [31:0] exp);
		for (int i = 0; i < 40 && diff_value !== exp; i++) cyc(1);
	endtask

	task automatic ramp_step(input logic signed [15:0] v, input logic e);
		@(posedge core_clk);
		ch3 <= v;
		cyc(3);
		`CHK(ramp_enable, e)
	endtask

	task automatic test_diag();
		logic [95:0] dflt;
		dflt = {32'h0, 16'd44, 16'd33, 16'd22, 16'd11};
		@(posedge core_clk);
		ch0 <= 16'd11;
		ch1 <= 16'd22;
		ch2 <= 16'd33;
		ch3 <= 16'd44;
		cyc(10);
		`CHK(fb_data, dflt)
		`CHK(shown, dflt)
		wr(A_MAP_BASE + 8'h14, 32'ha);
		cyc(10);
		`CHK(fb_data, {16'd33, 80'h0})
		`CHK(shown, {16'd33, 80'h0})
		rd(A_DIAG_BASE + 8'h14, rdv);
		`CHK(rdv, 32'd33)
		wr(A_MAP_BASE + 8'h14, 32'h0);
		cyc(10);
		`CHK(fb_data, dflt)
	endtask

	task automatic test_thr();
		int v0[4] = '{100, 101, 80, 49};
		int v1[4] = '{-10, -11, -5, 1};
		logic [1:0] e[4] = '{2'b00, 2'b11, 2'b11, 2'b00};
		wr(A_THR_BASE + O_THR_CFG, 32'h0);
		wr(A_THR_BASE + O_THR_ON, 32'd100);
		wr(A_THR_BASE + O_THR_OFF, 32'd50);
		wr(A_THR_BASE + A_THR_STRIDE + O_THR_CFG, 32'h5);
		wr(A_THR_BASE + A_THR_STRIDE + O_THR_ON, 32'hfffffff6);
		wr(A_THR_BASE + A_THR_STRIDE + O_THR_OFF, 32'h0);
		for (int i = 0; i < 4; i++) begin
			@(posedge core_clk);
			ch0 <= 16'(v0[i]);
			ch1 <= 16'(v1[i]);
			cyc(3);
			`CHK(thr_out, e[i])
		end
	endtask

	task automatic test_range();
		int v[6] = '{201, 160, 140, -201, -160, -140};
		logic e[6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
		wr(A_RNG_CFG, 32'h2);
		wr(A_RNG_UP_ON, 32'd200);
		wr(A_RNG_UP_OFF, 32'd150);
		wr(A_RNG_LO_ON, 32'hffffff38);
		wr(A_RNG_LO_OFF, 32'hffffff6a);
		for (int i = 0; i < 6; i++) begin
			@(posedge core_clk);
			ch2 <= 16'(v[i]);
			cyc(3);
			`CHK(range_out, e[i])
		end
	endtask

	task automatic test_irq();
		wr(A_IRQ_EN, 32'h1);
		wr(A_IRQ_CLR, 32'h1f);
		@(posedge core_clk);
		ch0 <= 16'd101;
		cyc(4);
		`CHK(irq, 1'b1)
		rd(A_IRQ_STAT, rdv);
		`CHK(rdv[0], 1'b1)
		rd(A_STATUS, rdv);
		`CHK(rdv[1:0], 2'b01)
		wr(A_IRQ_CLR, 32'h1);
		cyc(2);
		`CHK(irq, 1'b0)
		wr(A_IRQ_EN, 32'h0);
		@(posedge core_clk);
		ch0 <= 16'd40;
		cyc(3);
		@(posedge core_clk);
		ch0 <= 16'd101;
		cyc(3);
		`CHK(irq, 1'b0)
		rd(A_IRQ_STAT, rdv);
		`CHK(rdv[0], 1'b1)
		rd(8'hfc, rdv);
		`CHK(rdv, 32'h0)
	endtask

	task automatic test_ramp();
		ramp_step(16'd1000, 1'b1);
		wr(A_RMP_CFG, 32'hb);
		wr(A_RMP_GRAD, 32'h0);
		wr(A_RMP_ABS, 32'd10);
		wr(A_RMP_PCT, 32'd5);
		wr(A_RMP_HYST, 32'd1020);
		wr(A_CTRL, 32'h1);
		cyc(3);
		rd(A_RMP_LIM, rdv);
		`CHK(rdv, 32'd1060)
		ramp_step(16'd1061, 1'b0);
		ramp_step(16'd1050, 1'b0);
		ramp_step(16'd1010, 1'b1);
		wr(A_CTRL, 32'h2);
		ramp_step(16'd1000, 1'b1);
		wr(A_RMP_CFG, 32'hf);
		wr(A_CTRL, 32'h1);
		cyc(3);
		rd(A_RMP_LIM, rdv);
		`CHK(rdv, 32'd940)
		ramp_step(16'd939, 1'b0);
		wr(A_CTRL, 32'h2);
		ramp_step(16'd1000, 1'b1);
		wr(A_RMP_CFG, 32'h1b);
		wr(A_CTRL, 32'h1);
		ramp_step(16'd1100, 1'b0);
		wr(A_CTRL, 32'h4);
		ramp_step(16'd1100, 1'b0);
		ramp_step(16'd1000, 1'b0);
		wr(A_CTRL, 32'h4);
		cyc(2);
		`CHK(ramp_enable, 1'b1)
	endtask

	task automatic test_grad();
		logic [31:0] cfg[3] = '{32'hb, 32'hf, 32'h3};
		logic [31:0] step[3] = '{32'h3, 32'hfffffffd, 32'h3};
		int gap[3] = '{8, 8, 9998};
		// Two reads gap plus two edges apart see exactly one tick of the selected time base.
		for (int i = 0; i < 3; i++) begin
			wr(A_CTRL, 32'h2);
			wr(A_RMP_CFG, cfg[i]);
			wr(A_RMP_GRAD, 32'h3);
			wr(A_RMP_PCT, 32'h0);
			wr(A_CTRL, 32'h1);
			cyc(3);
			rd(A_RMP_LIM, rdv);
			cyc(gap[i]);
			rd(A_RMP_LIM, rdv2);
			`CHK(rdv2 - rdv, step[i])
		end
		wr(A_CTRL, 32'h2);
		cyc(2);
		`CHK(ramp_enable, 1'b1)
	endtask

	task automatic test_diff();
		@(posedge core_clk);
		ch0 <= 16'd60;
		wr(A_DIF_CFG, 32'h0);
		wr(A_DIF_INT, 32'h2);
		cyc(60);
		`CHK(diff_value, 32'sd0)
		@(posedge core_clk);
		ch0 <= -16'sd40;
		wait_diff(-32'sd50);
		`CHK(diff_value, -32'sd50)
		wr(A_DIF_CFG, 32'h4);
		@(posedge core_clk);
		ch0 <= -16'sd100;
		wait_diff(32'sd30);
		`CHK(diff_value, 32'sd30)
	endtask

	initial begin
		repeat (20) @(posedge core_clk);
		rst <= 1'b0;
		cyc(2);
		test_diag();
		test_thr();
		test_range();
		test_irq();
		test_ramp();
		test_grad();
		test_diff();
		wrap_up();
	end
endmodule
`default_nettype wire

/* File: verilog/avm_core.sv */
// Analogue value monitoring: thresholds, range, diagnostics, ramp and differential.
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module avm_core import avm_pkg::*; #(
	parameter int W = 16,
	parameter int TICKS_MS = TICKS_MS_DEF
) (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic rst,
	// Digitised channels, same clock domain.
	input wire logic signed [W-1:0] analog_channel_zero,
	input wire logic signed [W-1:0] analog_channel_one,
	input wire logic signed [W-1:0] analog_channel_two,
	input wire logic signed [W-1:0] analog_channel_three,
	// Register port.
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Monitor results.
	output logic [N_THR-1:0] thr_out,
	output logic range_out,
	output logic ramp_enable,
	output logic signed [31:0] diff_value,
	// Fieldbus and display.
	output logic [N_DIAG*W-1:0] fb_data,
	output logic [2:0] disp_id,
	output logic [W-1:0] disp_value,
	output logic disp_valid,
	// Interrupt.
	output logic irq
);
	function automatic logic hit(input logic lt, input logic signed [31:0] v, input logic signed [31:0] t);
		hit = lt ? (v < t) : (v > t);
	endfunction

	function automatic logic [7:0] thr_addr(input int i, input logic [7:0] off);
		thr_addr = A_THR_BASE + 8'(i) * A_THR_STRIDE + off;
	endfunction

	function automatic logic signed [31:0] sx(input logic signed [W-1:0] v);
		sx = 32'(v);
	endfunction

	logic signed [W-1:0] ch [N_CH];
	assign ch[0] = analog_channel_zero;
	assign ch[1] = analog_channel_one;
	assign ch[2] = analog_channel_two;
	assign ch[3] = analog_channel_three;

	logic [2:0] thr_cfg_q [N_THR];
	logic signed [W-1:0] thr_on_q [N_THR];
	logic signed [W-1:0] thr_off_q [N_THR];
	logic [1:0] rng_ch_q;
	logic signed [W-1:0] rng_up_on_q, rng_up_off_q, rng_lo_on_q, rng_lo_off_q;
	logic [4:0] rmp_cfg_q;
	logic signed [W-1:0] rmp_grad_q, rmp_abs_q, rmp_hyst_q;
	logic [15:0] rmp_pct_q;
	logic [2:0] dif_cfg_q;
	logic [15:0] dif_int_q;
	logic [3:0] map_q [N_DIAG];
	logic [N_EV-1:0] irq_stat_q, irq_en_q, ev;

	wire wr_ctrl = reg_wr && reg_addr == A_CTRL;
	wire start = wr_ctrl && reg_wdata[CTRL_START];
	wire stop = wr_ctrl && reg_wdata[CTRL_STOP];
	wire ack = wr_ctrl && reg_wdata[CTRL_ACK];

	// Configuration registers.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			for (int i = 0; i < N_THR; i++) begin
				thr_cfg_q[i] <= 3'h0;
				thr_on_q[i] <= THR_RST;
				thr_off_q[i] <= THR_RST;
			end
			for (int k = 0; k < N_DIAG; k++) map_q[k] <= 4'h0;
			rng_ch_q <= 2'h0;
			rng_up_on_q <= THR_RST;
			rng_up_off_q <= THR_RST;
			rng_lo_on_q <= THR_RST;
			rng_lo_off_q <= THR_RST;
			rmp_cfg_q <= 5'h00;
			rmp_grad_q <= THR_RST;
			rmp_abs_q <= THR_RST;
			rmp_pct_q <= 16'h0000;
			rmp_hyst_q <= THR_RST;
			dif_cfg_q <= 3'h0;
			dif_int_q <= DIF_INT_RST;
			irq_en_q <= '0;
		end else if (reg_wr) begin
			for (int i = 0; i < N_THR; i++) begin
				if (reg_addr == thr_addr(i, O_THR_CFG)) thr_cfg_q[i] <= reg_wdata[2:0];
				if (reg_addr == thr_addr(i, O_THR_ON)) thr_on_q[i] <= reg_wdata[W-1:0];
				if (reg_addr == thr_addr(i, O_THR_OFF)) thr_off_q[i] <= reg_wdata[W-1:0];
			end
			for (int k = 0; k < N_DIAG; k++) begin
				if (reg_addr == A_MAP_BASE + 8'(k * 4)) map_q[k] <= reg_wdata[3:0];
			end
			case (reg_addr)
				A_RNG_CFG: rng_ch_q <= reg_wdata[1:0];
				A_RNG_UP_ON: rng_up_on_q <= reg_wdata[W-1:0];
				A_RNG_UP_OFF: rng_up_off_q <= reg_wdata[W-1:0];
				A_RNG_LO_ON: rng_lo_on_q <= reg_wdata[W-1:0];
				A_RNG_LO_OFF: rng_lo_off_q <= reg_wdata[W-1:0];
				A_RMP_CFG: rmp_cfg_q <= reg_wdata[4:0];
				A_RMP_GRAD: rmp_grad_q <= reg_wdata[W-1:0];
				A_RMP_ABS: rmp_abs_q <= reg_wdata[W-1:0];
				A_RMP_PCT: rmp_pct_q <= reg_wdata[15:0];
				A_RMP_HYST: rmp_hyst_q <= reg_wdata[W-1:0];
				A_DIF_CFG: dif_cfg_q <= reg_wdata[2:0];
				A_DIF_INT: dif_int_q <= reg_wdata[15:0];
				A_IRQ_EN: irq_en_q <= reg_wdata[N_EV-1:0];
				default: ;
			endcase
		end
	end

	// Threshold monitors with hysteresis.
	logic [N_THR-1:0] thr_out_d, thr_on_hit, thr_off_hit;
	always_comb begin
		for (int i = 0; i < N_THR; i++) begin
			thr_on_hit[i] = hit(thr_cfg_q[i][CFG_MODE], sx(ch[thr_cfg_q[i][1:0]]), sx(thr_on_q[i]));
			thr_off_hit[i] = hit(!thr_cfg_q[i][CFG_MODE], sx(ch[thr_cfg_q[i][1:0]]), sx(thr_off_q[i]));
			thr_out_d[i] = thr_out[i] ? !thr_off_hit[i] : thr_on_hit[i];
		end
	end
	always_ff @(posedge core_clk) begin
		if (rst) thr_out <= '0;
		else thr_out <= thr_out_d;
	end

	// Range monitor: leaves the band upward or downward, each side with hysteresis.
	logic rng_up_q, rng_lo_q, rng_up_d, rng_lo_d;
	wire signed [31:0] rng_v = sx(ch[rng_ch_q]);
	always_comb begin
		rng_up_d = rng_up_q ? !(rng_v < sx(rng_up_off_q)) : (rng_v > sx(rng_up_on_q));
		rng_lo_d = rng_lo_q ? !(rng_v > sx(rng_lo_off_q)) : (rng_v < sx(rng_lo_on_q));
	end
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rng_up_q <= 1'b0;
			rng_lo_q <= 1'b0;
			range_out <= 1'b0;
		end else begin
			rng_up_q <= rng_up_d;
			rng_lo_q <= rng_lo_d;
			range_out <= rng_up_d | rng_lo_d;
		end
	end

	// Millisecond and second time base; the ramp uses either tick, the differential only the millisecond one.
	logic [31:0] ms_cnt_q;
	logic [9:0] s_cnt_q;
	logic tick_ms_q, tick_s_q;
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ms_cnt_q <= '0;
			s_cnt_q <= '0;
			tick_ms_q <= 1'b0;
			tick_s_q <= 1'b0;
		end else begin
			tick_ms_q <= ms_cnt_q == 32'(TICKS_MS - 1);
			tick_s_q <= ms_cnt_q == 32'(TICKS_MS - 1) && s_cnt_q == MS_PER_S - 10'h001;
			if (ms_cnt_q == 32'(TICKS_MS - 1)) begin
				ms_cnt_q <= '0;
				s_cnt_q <= (s_cnt_q == MS_PER_S - 10'h001) ? 10'h000 : s_cnt_q + 10'h001;
			end else begin
				ms_cnt_q <= ms_cnt_q + 32'h1;
			end
		end
	end

	// Ramp monitor.
	avm_rmp_state_t rmp_st_q;
	logic signed [31:0] rmp_base_q, rmp_lim, rmp_mag, rmp_pctv;
	wire signed [31:0] rmp_v = sx(ch[rmp_cfg_q[1:0]]);
	wire rmp_lower = rmp_cfg_q[CFG_MODE];
	wire rmp_tick = rmp_cfg_q[RMP_MS] ? tick_ms_q : tick_s_q;
	always_comb begin
		rmp_mag = rmp_base_q < 0 ? -rmp_base_q : rmp_base_q;
		rmp_pctv = 32'((48'(rmp_mag) * 48'(rmp_pct_q)) / 48'(PCT_DIV));
		if (rmp_lower) rmp_lim = rmp_base_q - sx(rmp_abs_q) - rmp_pctv;
		else rmp_lim = rmp_base_q + sx(rmp_abs_q) + rmp_pctv;
	end
	wire rmp_viol = rmp_st_q == AVM_RMP_TRACK && hit(rmp_lower, rmp_v, rmp_lim);
	wire rmp_back = hit(!rmp_lower, rmp_v, sx(rmp_hyst_q));
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rmp_st_q <= AVM_RMP_IDLE;
			rmp_base_q <= '0;
		end else if (stop) begin
			rmp_st_q <= AVM_RMP_IDLE;
		end else if (start) begin
			rmp_st_q <= AVM_RMP_TRACK;
			rmp_base_q <= rmp_v;
		end else if (rmp_st_q == AVM_RMP_TRACK && rmp_tick) begin
			rmp_base_q <= rmp_lower ? rmp_base_q - sx(rmp_grad_q) : rmp_base_q + sx(rmp_grad_q);
		end
	end
	// The enable stays high while no ramp runs so that idle channels never block.
	always_ff @(posedge core_clk) begin
		if (rst || start || rmp_st_q == AVM_RMP_IDLE) ramp_enable <= 1'b1;
		else if (rmp_viol) ramp_enable <= 1'b0;
		else if (!ramp_enable) begin
			if (rmp_cfg_q[RMP_MAN]) ramp_enable <= ack;
			else ramp_enable <= rmp_back;
		end
	end

	// Differential over the configured interval in milliseconds.
	logic [15:0] dif_cnt_q;
	logic signed [31:0] dif_ref_q, dif_q;
	logic dif_ev;
	wire [15:0] dif_ival = dif_int_q == 16'h0000 ? 16'h0001 : dif_int_q;
	wire signed [31:0] dif_v = sx(ch[dif_cfg_q[1:0]]);
	always_comb begin
		dif_ev = tick_ms_q && dif_cnt_q >= dif_ival - 16'h0001;
		dif_q = (dif_v - dif_ref_q) / $signed({16'h0000, dif_ival});
	end
	always_ff @(posedge core_clk) begin
		if (rst) begin
			dif_cnt_q <= '0;
			dif_ref_q <= '0;
			diff_value <= '0;
		end else if (tick_ms_q) begin
			dif_cnt_q <= dif_ev ? 16'h0000 : dif_cnt_q + 16'h0001;
			if (dif_ev) begin
				dif_ref_q <= dif_v;
				diff_value <= (dif_cfg_q[CFG_MODE] && dif_q < 0) ? -dif_q : dif_q;
			end
		end
	end

	// Diagnostic mapping to data identifiers one to six.
	logic [W-1:0] diag_v [N_DIAG];
	logic any_map;
	always_comb begin
		any_map = 1'b0;
		for (int k = 0; k < N_DIAG; k++) any_map = any_map | map_q[k][MAP_EN];
		for (int k = 0; k < N_DIAG; k++) begin
			diag_v[k] = '0;
			if (any_map) begin
				if (map_q[k][MAP_EN]) begin
					if (map_q[k][2] == 1'b0) diag_v[k] = ch[map_q[k][1:0]];
					else if (map_q[k][2:0] == SRC_DIFF) diag_v[k] = diff_value[W-1:0];
					else if (map_q[k][2:0] == SRC_RAMP) diag_v[k] = rmp_lim[W-1:0];
				end
			end else if (k < N_DEF) begin
				diag_v[k] = ch[k];
			end
		end
	end
	always_ff @(posedge core_clk) begin
		if (rst) fb_data <= '0;
		else for (int k = 0; k < N_DIAG; k++) fb_data[k*W +: W] <= diag_v[k];
	end
	// Display stream walks the identifiers one per cycle; disp_id 0 is identifier one.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			disp_id <= 3'h0;
			disp_value <= '0;
			disp_valid <= 1'b0;
		end else begin
			disp_id <= (disp_id == 3'(N_DIAG - 1)) ? 3'h0 : disp_id + 3'h1;
			disp_value <= diag_v[(disp_id == 3'(N_DIAG - 1)) ? 3'h0 : disp_id + 3'h1];
			disp_valid <= 1'b1;
		end
	end

	// Interrupt status: a new event wins over a clear in the same cycle.
	always_comb begin
		ev = '0;
		ev[EV_THR0 +: N_THR] = thr_out_d & ~thr_out;
		ev[EV_RNG] = (rng_up_d | rng_lo_d) & ~range_out;
		ev[EV_RAMP] = rmp_viol & ramp_enable;
		ev[EV_DIFF] = dif_ev;
	end
	always_ff @(posedge core_clk) begin
		if (rst) irq_stat_q <= '0;
		else if (reg_wr && reg_addr == A_IRQ_CLR) irq_stat_q <= (irq_stat_q & ~reg_wdata[N_EV-1:0]) | ev;
		else irq_stat_q <= irq_stat_q | ev;
	end
	always_ff @(posedge core_clk) begin
		if (rst) irq <= 1'b0;
		else irq <= |(((irq_stat_q & ~((reg_wr && reg_addr == A_IRQ_CLR) ? reg_wdata[N_EV-1:0] : '0)) | ev) & irq_en_q);
	end

	// Read port: data valid only in the cycle after the strobe, zero otherwise.
	logic [31:0] rd_d;
	always_comb begin
		rd_d = '0;
		case (reg_addr)
			A_STATUS: rd_d = 32'({rmp_st_q == AVM_RMP_TRACK, ramp_enable, range_out, thr_out});
			A_IRQ_STAT: rd_d = 32'(irq_stat_q);
			A_IRQ_EN: rd_d = 32'(irq_en_q);
			A_RNG_CFG: rd_d = 32'(rng_ch_q);
			A_RNG_UP_ON: rd_d = sx(rng_up_on_q);
			A_RNG_UP_OFF: rd_d = sx(rng_up_off_q);
			A_RNG_LO_ON: rd_d = sx(rng_lo_on_q);
			A_RNG_LO_OFF: rd_d = sx(rng_lo_off_q);
			A_RMP_CFG: rd_d = 32'(rmp_cfg_q);
			A_RMP_GRAD: rd_d = sx(rmp_grad_q);
			A_RMP_ABS: rd_d = sx(rmp_abs_q);
			A_RMP_PCT: rd_d = 32'(rmp_pct_q);
			A_RMP_HYST: rd_d = sx(rmp_hyst_q);
			A_DIF_CFG: rd_d = 32'(dif_cfg_q);
			A_DIF_INT: rd_d = 32'(dif_int_q);
			A_RMP_LIM: rd_d = rmp_lim;
			A_DIF_VAL: rd_d = diff_value;
			default: ;
		endcase
		for (int i = 0; i < N_THR; i++) begin
			if (reg_addr == thr_addr(i, O_THR_CFG)) rd_d = 32'(thr_cfg_q[i]);
			if (reg_addr == thr_addr(i, O_THR_ON)) rd_d = sx(thr_on_q[i]);
			if (reg_addr == thr_addr(i, O_THR_OFF)) rd_d = sx(thr_off_q[i]);
		end
		for (int k = 0; k < N_DIAG; k++) begin
			if (reg_addr == A_MAP_BASE + 8'(k * 4)) rd_d = 32'(map_q[k]);
			if (reg_addr == A_DIAG_BASE + 8'(k * 4)) rd_d = 32'(fb_data[k*W +: W]);
		end
	end
	always_ff @(posedge core_clk) begin
		if (rst) reg_rdata <= '0;
		else reg_rdata <= reg_rd ? rd_d : 32'h0;
	end

	// Checks.
	AST_THR_ON: assert property (@(posedge core_clk) disable iff (rst) $rose(thr_out[0]) |-> $past(thr_on_hit[0]))
		else $error("threshold output rose without its on condition");
	AST_THR_HOLD: assert property (@(posedge core_clk) disable iff (rst)
		thr_out[1] && !thr_off_hit[1] |=> thr_out[1])
		else $error("threshold output dropped before the off value");
	AST_RNG_UP: assert property (@(posedge core_clk) disable iff (rst) rng_v > sx(rng_up_on_q) |=> range_out)
		else $error("range output missed an upper crossing");
	AST_DIAG_DEF: assert property (@(posedge core_clk) disable iff (rst)
		!any_map |=> fb_data[2*W +: W] == $past(analog_channel_two))
		else $error("default mapping of channel two wrong");
	AST_DIAG_USER: assert property (@(posedge core_clk) disable iff (rst)
		map_q[5] == 4'ha |=> fb_data[5*W +: W] == $past(analog_channel_two))
		else $error("user mapping not applied");
	AST_RMP_START: assert property (@(posedge core_clk) disable iff (rst)
		start && !stop |=> rmp_base_q == $past(rmp_v) && ramp_enable)
		else $error("ramp base not loaded from input");
	AST_RMP_VIOL: assert property (@(posedge core_clk) disable iff (rst)
		rmp_viol && !start && !stop |=> !ramp_enable)
		else $error("ramp violation did not drop enable");
	AST_RMP_MAN: assert property (@(posedge core_clk) disable iff (rst)
		rmp_cfg_q[RMP_MAN] && !ramp_enable && !ack && !start && !stop && rmp_st_q == AVM_RMP_TRACK |=> !ramp_enable)
		else $error("manual ramp re-enabled without request");
	AST_DIF_ABS: assert property (@(posedge core_clk) disable iff (rst)
		dif_ev && dif_cfg_q[CFG_MODE] |=> diff_value >= 0)
		else $error("magnitude differential is negative");
endmodule
`default_nettype wire

/* File: verilog/avm_pkg.sv */
// Shared constants for the analogue value monitoring block.
package avm_pkg;
	// Register byte addresses.
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_STATUS = 8'h04;
	localparam logic [7:0] A_IRQ_STAT = 8'h08;
	localparam logic [7:0] A_IRQ_EN = 8'h0c;
	localparam logic [7:0] A_IRQ_CLR = 8'h10;
	localparam logic [7:0] A_THR_BASE = 8'h20;
	localparam logic [7:0] A_THR_STRIDE = 8'h10;
	localparam logic [7:0] O_THR_CFG = 8'h00;
	localparam logic [7:0] O_THR_ON = 8'h04;
	localparam logic [7:0] O_THR_OFF = 8'h08;
	localparam logic [7:0] A_RNG_CFG = 8'h40;
	localparam logic [7:0] A_RNG_UP_ON = 8'h44;
	localparam logic [7:0] A_RNG_UP_OFF = 8'h48;
	localparam logic [7:0] A_RNG_LO_ON = 8'h4c;
	localparam logic [7:0] A_RNG_LO_OFF = 8'h50;
	localparam logic [7:0] A_RMP_CFG = 8'h60;
	localparam logic [7:0] A_RMP_GRAD = 8'h64;
	localparam logic [7:0] A_RMP_ABS = 8'h68;
	localparam logic [7:0] A_RMP_PCT = 8'h6c;
	localparam logic [7:0] A_RMP_HYST = 8'h70;
	localparam logic [7:0] A_DIF_CFG = 8'h80;
	localparam logic [7:0] A_DIF_INT = 8'h84;
	localparam logic [7:0] A_MAP_BASE = 8'ha0;
	localparam logic [7:0] A_DIAG_BASE = 8'hc0;
	localparam logic [7:0] A_RMP_LIM = 8'he0;
	localparam logic [7:0] A_DIF_VAL = 8'he4;
	// Field positions.
	localparam int CTRL_START = 0;
	localparam int CTRL_STOP = 1;
	localparam int CTRL_ACK = 2;
	localparam int CFG_MODE = 2;
	localparam int RMP_MS = 3;
	localparam int RMP_MAN = 4;
	localparam int MAP_EN = 3;
	localparam int EV_THR0 = 0;
	localparam int EV_RNG = 2;
	localparam int EV_RAMP = 3;
	localparam int EV_DIFF = 4;
	localparam int N_EV = 5;
	// Diagnostic source codes beyond the four channels.
	localparam logic [2:0] SRC_DIFF = 3'h4;
	localparam logic [2:0] SRC_RAMP = 3'h5;
	// Sizes.
	localparam int N_CH = 4;
	localparam int N_THR = 2;
	localparam int N_DIAG = 6;
	localparam int N_DEF = 4;
	// Timing.
	localparam int CLK_PERIOD_PS = 5000;
	localparam int T_MS_PS = 1000000000;
	localparam int TICKS_MS_DEF = T_MS_PS / CLK_PERIOD_PS;
	localparam logic [9:0] MS_PER_S = 10'h3e8;
	localparam int PCT_DIV = 100;
	// Values after reset.
	localparam logic [15:0] DIF_INT_RST = 16'h0001;
	localparam logic [15:0] THR_RST = 16'h0000;
	typedef enum logic {AVM_RMP_IDLE, AVM_RMP_TRACK} avm_rmp_state_t;
endpackage
